// ==== pkg/t1dl_consts.svh ====
`ifndef T1DL_CONSTS_SVH
`define T1DL_CONSTS_SVH
// ***********************************
// register indices (byte address = 4 x index)
// ***********************************
`define T1DL_IDX_STATUS     7'h21
`define T1DL_IDX_CRC_HIGH   7'h25
`define T1DL_IDX_CRC_LOW    7'h26
`define T1DL_IDX_FE_COUNT   7'h27
`define T1DL_IDX_RX_BYTE    7'h28
`define T1DL_IDX_MATCH_A    7'h29
`define T1DL_IDX_MATCH_B    7'h2a
`define T1DL_IDX_CONTROL    7'h40
`define T1DL_IDX_IRQ_MASK   7'h6f
`define T1DL_IDX_TX_BYTE    7'h7e
// ***********************************
// field positions
// ***********************************
`define T1DL_CTL_DESTUFF    0
`define T1DL_CTL_ESF        3
`define T1DL_CTL_STUFF      4
`define T1DL_CTL_FS_COUNT   5
`define T1DL_ST_ABORT       1
`define T1DL_ST_MATCH       2
`define T1DL_ST_TX_EMPTY    3
`define T1DL_ST_RX_FULL     4
// ***********************************
// reset values and limits
// ***********************************
`define T1DL_RST_BYTE       8'h00
`define T1DL_CRC_MAX        16'hffff
`define T1DL_FE_MAX         8'hff
`define T1DL_FLAG_RUN       4'h5
`define T1DL_ABORT_RUN      4'h8
`define T1DL_BITS_PER_BYTE  4'h8
`endif

// ==== pkg/t1dl_pkg.sv ====
package t1dl_pkg;
    typedef enum logic [1:0] {
        T1DL_TX_IDLE = 2'b01,
        T1DL_TX_SEND = 2'b10
    } t1dl_tx_state_t;

    typedef struct packed {
        logic           rx_clk_s1;
        logic           rx_clk_s2;
        logic           rx_clk_prev;
        logic           rx_dat_s1;
        logic           rx_dat_s2;
        logic           tx_clk_s1;
        logic           tx_clk_s2;
        logic           tx_clk_prev;
        logic [7:0]     ctrl;
        logic [7:0]     mask;
        logic [7:0]     status;
        logic [7:0]     match_a;
        logic [7:0]     match_b;
        logic [7:0]     tx_byte;
        logic [7:0]     rx_byte;
        logic [7:0]     rx_sr;
        logic [3:0]     rx_cnt;
        logic [3:0]     rx_ones;
        logic [7:0]     tx_sr;
        logic [3:0]     tx_cnt;
        logic [3:0]     tx_ones;
        logic           tx_bit;
        t1dl_tx_state_t tx_state;
        logic [15:0]    crc_acc;
        logic [15:0]    crc_cnt;
        logic [7:0]     fe_acc;
        logic [7:0]     fe_cnt;
        logic [31:0]    prdata;
        logic           pslverr;
    } t1dl_state_t;
endpackage : t1dl_pkg

// ==== design/t1dl_link_counters.sv ====
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "t1dl_consts.svh"

module t1dl_link_counters (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_link_clk,
    input  wire logic        rx_link_data,
    input  wire logic        tx_link_clk,
    output logic             tx_link_data,
    input  wire logic        rx_out_of_sync,
    input  wire logic        crc_word_error,
    input  wire logic        framing_bit_error,
    input  wire logic        framing_bit_is_fs,
    input  wire logic        one_second_tick,
    output logic             second_interrupt_out_n
);
    import t1dl_pkg::*;

    t1dl_state_t s_q;
    t1dl_state_t s_d;

    // ***********************************
    // address decode
    // ***********************************
    function automatic logic reg_hit(input logic [11:0] addr, input logic [6:0] idx);
        reg_hit = (addr[1:0] == 2'b00) && (addr[11:9] == 3'b000) && (addr[8:2] == idx);
    endfunction : reg_hit

    logic       rx_edge;
    logic       tx_edge;
    logic       rx_bit;
    logic       drop_zero;
    logic [7:0] rx_next_sr;
    logic       byte_done;
    logic [1:0] match_hit;
    logic       wr_access;
    logic       setup;
    logic       crc_ev;
    logic       fe_ev;
    logic       esf;

    assign rx_edge   = s_q.rx_clk_s2 & ~s_q.rx_clk_prev;
    assign tx_edge   = s_q.tx_clk_s2 & ~s_q.tx_clk_prev;
    assign rx_bit    = s_q.rx_dat_s2;
    assign esf       = s_q.ctrl[`T1DL_CTL_ESF];
    assign setup     = psel & ~penable;
    assign wr_access = psel & penable & pwrite;
    // exactly five ones then zero is a stuffed bit; six or more is a flag/abort
    assign drop_zero = s_q.ctrl[`T1DL_CTL_DESTUFF] & ~rx_bit & (s_q.rx_ones == `T1DL_FLAG_RUN);
    assign rx_next_sr = {rx_bit, s_q.rx_sr[7:1]};
    assign byte_done  = rx_edge & ~drop_zero & (s_q.rx_cnt == `T1DL_BITS_PER_BYTE - 4'h1);
    assign crc_ev = crc_word_error & esf & ~rx_out_of_sync;
    assign fe_ev  = framing_bit_error & ~rx_out_of_sync
                  & (esf | ~framing_bit_is_fs | s_q.ctrl[`T1DL_CTL_FS_COUNT]);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_match
            assign match_hit[gi] = (rx_next_sr == (gi == 0 ? s_q.match_a : s_q.match_b));
        end
    endgenerate

    // ***********************************
    // next state
    // ***********************************
    always_comb begin
        s_d = s_q;
        s_d.rx_clk_s1   = rx_link_clk;
        s_d.rx_clk_s2   = s_q.rx_clk_s1;
        s_d.rx_clk_prev = s_q.rx_clk_s2;
        s_d.rx_dat_s1   = rx_link_data;
        s_d.rx_dat_s2   = s_q.rx_dat_s1;
        s_d.tx_clk_s1   = tx_link_clk;
        s_d.tx_clk_s2   = s_q.tx_clk_s1;
        s_d.tx_clk_prev = s_q.tx_clk_s2;

        // error accumulators, transferred and restarted each second
        if (one_second_tick) begin
            s_d.crc_cnt = s_q.crc_acc;
            s_d.fe_cnt  = s_q.fe_acc;
            s_d.crc_acc = crc_ev ? 16'h0001 : 16'h0000;
            s_d.fe_acc  = fe_ev ? 8'h01 : 8'h00;
        end else begin
            if (crc_ev && s_q.crc_acc != `T1DL_CRC_MAX) begin
                s_d.crc_acc = s_q.crc_acc + 16'h0001;
            end
            if (fe_ev && s_q.fe_acc != `T1DL_FE_MAX) begin
                s_d.fe_acc = s_q.fe_acc + 8'h01;
            end
        end

        // software clears status with write-one; a same-cycle set wins below
        if (wr_access && reg_hit(paddr, `T1DL_IDX_STATUS)) begin
            s_d.status = s_q.status & ~pwdata[7:0];
        end
        if (wr_access && reg_hit(paddr, `T1DL_IDX_CONTROL)) begin
            s_d.ctrl = pwdata[7:0];
        end else if (wr_access && reg_hit(paddr, `T1DL_IDX_IRQ_MASK)) begin
            s_d.mask = pwdata[7:0];
        end else if (wr_access && reg_hit(paddr, `T1DL_IDX_MATCH_A)) begin
            s_d.match_a = pwdata[7:0];
        end else if (wr_access && reg_hit(paddr, `T1DL_IDX_MATCH_B)) begin
            s_d.match_b = pwdata[7:0];
        end else if (wr_access && reg_hit(paddr, `T1DL_IDX_TX_BYTE)) begin
            s_d.tx_byte = pwdata[7:0];
        end

        // receive path: destuff before assembly
        if (rx_edge) begin
            if (rx_bit) begin
                if (s_q.rx_ones != `T1DL_ABORT_RUN) begin
                    s_d.rx_ones = s_q.rx_ones + 4'h1;
                end
                if (s_q.rx_ones == `T1DL_ABORT_RUN - 4'h1) begin
                    s_d.status[`T1DL_ST_ABORT] = 1'b1;
                end
            end else begin
                s_d.rx_ones = 4'h0;
            end
            if (!drop_zero) begin
                s_d.rx_sr = rx_next_sr;
                if (byte_done) begin
                    s_d.rx_cnt  = 4'h0;
                    s_d.rx_byte = rx_next_sr;
                    s_d.status[`T1DL_ST_RX_FULL] = 1'b1;
                    if (|match_hit) begin
                        s_d.status[`T1DL_ST_MATCH] = 1'b1;
                    end
                end else begin
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                end
            end
        end

        // transmit path: idle until the first byte is written
        case (s_q.tx_state)
            T1DL_TX_IDLE: begin
                s_d.tx_bit = 1'b1;
                if (wr_access && reg_hit(paddr, `T1DL_IDX_TX_BYTE)) begin
                    s_d.tx_state = T1DL_TX_SEND;
                    s_d.tx_sr    = pwdata[7:0];
                    s_d.tx_cnt   = 4'h0;
                end
            end
            T1DL_TX_SEND: begin
                if (tx_edge) begin
                    if (s_q.ctrl[`T1DL_CTL_STUFF] && s_q.tx_ones == `T1DL_FLAG_RUN) begin
                        s_d.tx_bit  = 1'b0;
                        s_d.tx_ones = 4'h0;
                    end else begin
                        s_d.tx_bit  = s_q.tx_sr[0];
                        s_d.tx_ones = s_q.tx_sr[0] ? s_q.tx_ones + 4'h1 : 4'h0;
                        if (s_q.tx_cnt == `T1DL_BITS_PER_BYTE - 4'h1) begin
                            s_d.tx_cnt = 4'h0;
                            s_d.tx_sr  = s_q.tx_byte;
                            s_d.status[`T1DL_ST_TX_EMPTY] = 1'b1;
                        end else begin
                            s_d.tx_cnt = s_q.tx_cnt + 4'h1;
                            s_d.tx_sr  = {1'b0, s_q.tx_sr[7:1]};
                        end
                    end
                end
            end
            default: begin
                s_d.tx_state = T1DL_TX_IDLE;
            end
        endcase

        // read data captured in the setup cycle, ready in the access cycle
        if (setup) begin
            s_d.prdata  = 32'h0000_0000;
            s_d.pslverr = 1'b0;
            if (reg_hit(paddr, `T1DL_IDX_STATUS)) begin
                s_d.prdata[7:0] = s_q.status;
            end else if (reg_hit(paddr, `T1DL_IDX_CRC_HIGH)) begin
                s_d.prdata[7:0] = s_q.crc_cnt[15:8];
            end else if (reg_hit(paddr, `T1DL_IDX_CRC_LOW)) begin
                s_d.prdata[7:0] = s_q.crc_cnt[7:0];
            end else if (reg_hit(paddr, `T1DL_IDX_FE_COUNT)) begin
                s_d.prdata[7:0] = s_q.fe_cnt;
            end else if (reg_hit(paddr, `T1DL_IDX_RX_BYTE)) begin
                s_d.prdata[7:0] = s_q.rx_byte;
            end else if (reg_hit(paddr, `T1DL_IDX_MATCH_A)) begin
                s_d.prdata[7:0] = s_q.match_a;
            end else if (reg_hit(paddr, `T1DL_IDX_MATCH_B)) begin
                s_d.prdata[7:0] = s_q.match_b;
            end else if (reg_hit(paddr, `T1DL_IDX_CONTROL)) begin
                s_d.prdata[7:0] = s_q.ctrl;
            end else if (reg_hit(paddr, `T1DL_IDX_IRQ_MASK)) begin
                s_d.prdata[7:0] = s_q.mask;
            end else if (reg_hit(paddr, `T1DL_IDX_TX_BYTE)) begin
                s_d.prdata[7:0] = s_q.tx_byte;
            end else begin
                s_d.pslverr = 1'b1;
            end
        end
    end

    // ***********************************
    // state register
    // ***********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.tx_state <= T1DL_TX_IDLE;
            s_q.tx_bit   <= 1'b1;
            s_q.rx_byte  <= `T1DL_RST_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata       = s_q.prdata;
    assign pslverr      = s_q.pslverr & psel & penable;
    assign pready       = 1'b1;
    assign tx_link_data = s_q.tx_bit;
    // only link flags reach this pin; other sources live elsewhere in the framer
    assign second_interrupt_out_n = ~|(s_q.status & s_q.mask
        & 8'((1 << `T1DL_ST_RX_FULL) | (1 << `T1DL_ST_MATCH) | (1 << `T1DL_ST_TX_EMPTY)));

    // ***********************************
    // checks
    // ***********************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rx_five_ones;
        rx_edge && !rx_bit && s_q.ctrl[0] && s_q.rx_ones == 4'h5;
    endsequence

    sequence rx_zero_gone;
        s_q.rx_ones == 4'h0 && $stable(s_q.rx_sr);
    endsequence

    chk_crc_saturate: assert property (s_q.crc_acc == 16'hffff && !one_second_tick |=> s_q.crc_acc == 16'hffff)
        else $error("crc accumulator left saturation");
    chk_fe_saturate: assert property (s_q.fe_acc == 8'hff && !one_second_tick |=> s_q.fe_acc == 8'hff)
        else $error("frame error accumulator left saturation");
    chk_sync_inhibit: assert property (rx_out_of_sync && !one_second_tick
        |=> $stable(s_q.crc_acc) && $stable(s_q.fe_acc))
        else $error("counter moved while out of sync");
    chk_crc_esf_only: assert property (!esf && !one_second_tick |=> $stable(s_q.crc_acc))
        else $error("crc counted outside esf");
    chk_second_transfer: assert property (one_second_tick
        |=> s_q.crc_cnt == $past(s_q.crc_acc) && s_q.fe_cnt == $past(s_q.fe_acc) && s_q.crc_acc <= 16'h0001)
        else $error("one second transfer wrong");
    chk_rx_full_set: assert property (byte_done |=> s_q.status[4] && s_q.rx_byte == $past(rx_next_sr))
        else $error("full byte not posted");
    chk_match_set: assert property (byte_done && |match_hit |=> s_q.status[2])
        else $error("match flag missed");
    chk_destuff_drop: assert property (drop_zero && rx_edge |=> $stable(s_q.rx_cnt) && $stable(s_q.rx_sr))
        else $error("stuffed zero not removed");
    chk_keep_long_run: assert property (rx_edge && !rx_bit && s_q.rx_ones > 4'h5
        |=> s_q.rx_sr[7] == 1'b0 && s_q.rx_ones == 4'h0)
        else $error("zero after long run dropped");
    chk_abort_flag: assert property (rx_edge && rx_bit && s_q.rx_ones == 4'h7 |=> s_q.status[1])
        else $error("abort not flagged");
    chk_stuff_zero: assert property (s_q.tx_state == T1DL_TX_SEND && tx_edge && s_q.ctrl[4]
        && s_q.tx_ones == 4'h5 |=> !tx_link_data && $stable(s_q.tx_cnt))
        else $error("stuffed zero not sent");
    chk_tx_reload: assert property (s_q.tx_state == T1DL_TX_SEND && tx_edge && s_q.tx_cnt == 4'h7
        && !(s_q.ctrl[4] && s_q.tx_ones == 4'h5) |=> s_q.status[3] && s_q.tx_sr == $past(s_q.tx_byte))
        else $error("tx byte boundary wrong");
    chk_irq_low: assert property (s_q.status[4] && s_q.mask[4] |-> !second_interrupt_out_n)
        else $error("interrupt not driven");
    chk_run_before_drop: assert property (rx_five_ones |=> rx_zero_gone)
        else $error("stuffed zero reached the byte");

    // ***********************************
    // interrupt pin, bit order, transmit idle/load, set priority and accumulator restart checks
    // ***********************************
    chk_tx_irq_low: assert property (s_q.status[3] && s_q.mask[3] |-> !second_interrupt_out_n)
        else $error("tx empty interrupt not driven");

    chk_match_irq_low: assert property (s_q.status[2] && s_q.mask[2] |-> !second_interrupt_out_n)
        else $error("match interrupt not driven");

    chk_irq_release: assert property (!(|(s_q.status & s_q.mask & 8'h1c)) |-> second_interrupt_out_n)
        else $error("interrupt without unmasked flag");

    chk_rx_lsb_first: assert property (rx_edge && !drop_zero |=> s_q.rx_sr[7] == $past(rx_bit))
        else $error("received bit not shifted in at the top");

    chk_tx_lsb_first: assert property (s_q.tx_state == T1DL_TX_SEND && tx_edge
        && !(s_q.ctrl[4] && s_q.tx_ones == 4'h5) |=> tx_link_data == $past(s_q.tx_sr[0]))
        else $error("transmit bit order wrong");

    chk_tx_idle_high: assert property (s_q.tx_state == T1DL_TX_IDLE |-> tx_link_data)
        else $error("idle transmit line not high");

    chk_tx_first_load: assert property (s_q.tx_state == T1DL_TX_IDLE && wr_access
        && reg_hit(paddr, 7'h7e) |=> s_q.tx_state == T1DL_TX_SEND && s_q.tx_sr == $past(pwdata[7:0]))
        else $error("first transmit byte not loaded");

    // a clear in the same cycle as the set must lose
    chk_full_set_wins: assert property (byte_done && wr_access && reg_hit(paddr, 7'h21)
        && pwdata[4] |=> s_q.status[4])
        else $error("full flag lost to a clear");

    chk_acc_restart: assert property (one_second_tick && !crc_ev && !fe_ev
        |=> s_q.crc_acc == 16'h0000 && s_q.fe_acc == 8'h00)
        else $error("accumulator not restarted");
endmodule : t1dl_link_counters
`default_nettype wire

// ==== tb/t1dl_link_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// line side model, clocks only run inside frames
// ****
module t1dl_link_partner (
    input  wire logic tx_link_data,
    output logic      rx_link_clk,
    output logic      rx_link_data,
    output logic      tx_link_clk
);
    logic [15:0] tx_cap;
    initial begin
        rx_link_clk  = 1'b0;
        rx_link_data = 1'b0;
        tx_link_clk  = 1'b0;
        tx_cap       = 16'h0000;
    end
    task automatic send_rx(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rx_link_data = bits[i];
            #80.3 rx_link_clk = 1'b1;
            #80 rx_link_clk = 1'b0;
        end
        // released line must not hold a stale bit
        rx_link_data = ~rx_link_data;
    endtask : send_rx
    task automatic run_tx(input int n);
        for (int i = 0; i < n; i++) begin
            #80.3 tx_link_clk = 1'b1;
            #80 tx_link_clk = 1'b0;
            tx_cap[i] = tx_link_data;
        end
    endtask : run_tx
endmodule : t1dl_link_partner
`default_nettype wire

// ==== tb/tb_t1_data_link_and_error_counters.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "t1dl_consts.svh"
module tb_t1_data_link_and_error_counters;
    import t1dl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        second_interrupt_out_n, rx_out_of_sync, crc_word_error;
    logic        framing_bit_error, framing_bit_is_fs, one_second_tick;
    wire         rx_link_clk, rx_link_data, tx_link_clk, tx_link_data;
    int          failures, checks_done;

    t1dl_link_counters t1dl_link_counters_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_link_clk, .rx_link_data, .tx_link_clk, .tx_link_data,
        .rx_out_of_sync, .crc_word_error, .framing_bit_error, .framing_bit_is_fs,
        .one_second_tick, .second_interrupt_out_n
    );
    t1dl_link_partner t1dl_link_partner_inst (
        .tx_link_data, .rx_link_clk, .rx_link_data, .tx_link_clk
    );
    // ****
    // shared tasks
    // ****
    task automatic finish_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val
    task automatic apb(input logic w, input logic [6:0] idx, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {3'b000, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, read data and error are all taken at the same rising edge
        for (k = 0; k < 40; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 40) begin
            failures++;
            finish_test();
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input string name, input logic [6:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk_val(name, exp, rdata);
        chk_val("pslverr", 32'h0, {31'h0, rerr});
    endtask : rd
    task automatic ev(input logic c, input logic f);
        @(posedge pclk);
        crc_word_error    <= c;
        framing_bit_error <= f;
        @(posedge pclk);
        crc_word_error    <= 1'b0;
        framing_bit_error <= 1'b0;
    endtask : ev
    task automatic tick;
        @(posedge pclk);
        one_second_tick <= 1'b1;
        @(posedge pclk);
        one_second_tick <= 1'b0;
    endtask : tick
    task automatic irq(input logic exp);
        @(negedge pclk);
        chk_val("irq_n", {31'h0, exp}, {31'h0, second_interrupt_out_n});
    endtask : irq
    // ****
    // scenarios
    // ****
    task automatic t_regs;
        rd("fe_count", `T1DL_IDX_FE_COUNT, 32'h0);
        rd("status", `T1DL_IDX_STATUS, 32'h0);
        apb(1'b1, `T1DL_IDX_CRC_LOW, 32'h55);
        rd("crc_low", `T1DL_IDX_CRC_LOW, 32'h0);
        apb(1'b1, 7'h00, 32'h1);
        chk_val("unmapped_err", 32'h1, {31'h0, rerr});
        apb(1'b1, `T1DL_IDX_MATCH_A, 32'h1f);
        rd("match_a", `T1DL_IDX_MATCH_A, 32'h1f);
        $display("test regs done");
    endtask : t_regs
    task automatic t_counters;
        apb(1'b1, `T1DL_IDX_CONTROL, 32'h08);
        tick();
        repeat (3) ev(1'b1, 1'b1);
        rx_out_of_sync <= 1'b1;
        ev(1'b1, 1'b1);
        rx_out_of_sync <= 1'b0;
        tick();
        rd("crc_high", `T1DL_IDX_CRC_HIGH, 32'h0);
        rd("crc_low", `T1DL_IDX_CRC_LOW, 32'h3);
        rd("fe_count", `T1DL_IDX_FE_COUNT, 32'h3);
        tick();
        rd("crc_low", `T1DL_IDX_CRC_LOW, 32'h0);
        apb(1'b1, `T1DL_IDX_CONTROL, 32'h00);
        ev(1'b1, 1'b0);
        framing_bit_is_fs <= 1'b1;
        ev(1'b0, 1'b1);
        framing_bit_is_fs <= 1'b0;
        ev(1'b0, 1'b1);
        apb(1'b1, `T1DL_IDX_CONTROL, 32'h20);
        framing_bit_is_fs <= 1'b1;
        ev(1'b0, 1'b1);
        tick();
        rd("crc_low", `T1DL_IDX_CRC_LOW, 32'h0);
        rd("fe_count", `T1DL_IDX_FE_COUNT, 32'h2);
        apb(1'b1, `T1DL_IDX_CONTROL, 32'h08);
        // back to back events, one per cycle, past both limits
        @(posedge pclk);
        crc_word_error    <= 1'b1;
        framing_bit_error <= 1'b1;
        repeat (65540) @(posedge pclk);
        crc_word_error    <= 1'b0;
        framing_bit_error <= 1'b0;
        tick();
        rd("crc_high", `T1DL_IDX_CRC_HIGH, 32'hff);
        rd("crc_low", `T1DL_IDX_CRC_LOW, 32'hff);
        rd("fe_count", `T1DL_IDX_FE_COUNT, 32'hff);
        $display("test counters done");
    endtask : t_counters
    task automatic t_rx;
        apb(1'b1, `T1DL_IDX_CONTROL, 32'h01);
        apb(1'b1, `T1DL_IDX_IRQ_MASK, 32'h14);
        t1dl_link_partner_inst.send_rx(16'h001f, 9);
        rd("rx_byte", `T1DL_IDX_RX_BYTE, 32'h1f);
        rd("status", `T1DL_IDX_STATUS, 32'h14);
        irq(1'b0);
        apb(1'b1, `T1DL_IDX_STATUS, 32'h14);
        irq(1'b1);
        t1dl_link_partner_inst.send_rx(16'h003f, 8);
        rd("rx_byte", `T1DL_IDX_RX_BYTE, 32'h3f);
        apb(1'b1, `T1DL_IDX_STATUS, 32'h10);
        t1dl_link_partner_inst.send_rx(16'h00ff, 8);
        rd("status", `T1DL_IDX_STATUS, 32'h12);
        rd("rx_byte", `T1DL_IDX_RX_BYTE, 32'hff);
        $display("test rx done");
    endtask : t_rx
    task automatic t_tx;
        apb(1'b1, `T1DL_IDX_STATUS, 32'h1e);
        apb(1'b1, `T1DL_IDX_IRQ_MASK, 32'h08);
        apb(1'b1, `T1DL_IDX_CONTROL, 32'h10);
        apb(1'b1, `T1DL_IDX_TX_BYTE, 32'hff);
        t1dl_link_partner_inst.run_tx(9);
        chk_val("tx_bits", 32'h1df, {23'h0, t1dl_link_partner_inst.tx_cap[8:0]});
        irq(1'b0);
        rd("status", `T1DL_IDX_STATUS, 32'h08);
        t1dl_link_partner_inst.run_tx(9);
        chk_val("tx_bits", 32'h0fb, {23'h0, t1dl_link_partner_inst.tx_cap[8:0]});
        $display("test tx done");
    endtask : t_tx
    // ****
    // main sequence
    // ****
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        presetn           = 1'b0;
        psel              = 1'b0;
        penable           = 1'b0;
        pwrite            = 1'b0;
        paddr             = 12'h000;
        pwdata            = 32'h0;
        rx_out_of_sync    = 1'b0;
        crc_word_error    = 1'b0;
        framing_bit_error = 1'b0;
        framing_bit_is_fs = 1'b0;
        one_second_tick   = 1'b0;
        failures          = 0;
        checks_done       = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_counters();
        t_rx();
        t_tx();
        finish_test();
    end
endmodule : tb_t1_data_link_and_error_counters
`default_nettype wire
